// ---- src/dwcv_write_path.v ----
/*
 * write-path tracker of the memory device: picks the burst length of each
 * write, times the data window against write latency, marks the end of
 * burst from which recovery is counted and write-to-read only reported, and confines
 * data timing faults and in-tolerance strobe faults to the write that carried them.
 * assumes ck, cmd and strobe pins come from the controller's domain and are
 * sampled here; ck is much slower than core_clk; registers over Avalon-MM.
 */
// The address map and the Avalon-MM interface to the registers were decided locally.
// Functional notes
// - mode 10 forces four-beat chop always
// - mode 00, or 01 with a12 high: eight
// - mode 01 with a12 low: four-beat chop
// - recovery counted from edge after last beat
// - minor violations never hang the device
// - setup/hold error taints only that location
// - strobe tolerance only without crc, otf
// - strobe within six edges of latency
// - read after offending write still served
// - same-bank writes after long spacing allowed
// - other-group writes after short spacing allowed
// - all banks idle clears taint state
`timescale 1ns/1ps
`include "dwcv_defs.vh"
module dwcv_write_path (
  input  wire        core_clk,
  input  wire        reset_n,
  // pins from the controller, asynchronous to core_clk
  input  wire        ck_pin,
  input  wire        wr_cmd_pin,
  input  wire        rd_cmd_pin,
  input  wire        pre_cmd_pin,
  input  wire        all_idle_pin,
  input  wire        a12_pin,
  input  wire        dqs_fault_pin,
  input  wire        dq_fault_pin,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // device side status
  output reg         burst_end_r,
  output reg         taint_r,
  output reg         rd_grant_r
);

  // synchronised pin levels
  wire ck_s;
  wire wr_s;
  wire rd_s;
  wire pre_s;
  wire idle_s;
  wire a12_s;
  wire dqsf_s;
  wire dqf_s;
  wire ck_rise;

  wire [7:0] pins_async;
  wire [7:0] pins_sync;
  assign pins_async = {ck_pin, wr_cmd_pin, rd_cmd_pin, pre_cmd_pin,
                       all_idle_pin, a12_pin, dqs_fault_pin, dq_fault_pin};
  assign {ck_s, wr_s, rd_s, pre_s, idle_s, a12_s, dqsf_s, dqf_s} = pins_sync;

  // every pin passes two flops before any logic reads it
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      dwcv_sync u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .async_in (pins_async[gi]),
        .sync_out (pins_sync[gi])
      );
    end
  endgenerate

  dwcv_edge u_ck_edge (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .lvl_in   (ck_s),
    .rise     (ck_rise)
  );

  // burst length decode, shared by command capture and the end-of-burst line
  function [3:0] dwcv_beats;
    input [1:0] bl_mode;
    input       a12;
    begin
      case (bl_mode)
        `DWCV_BL_FIXED4: dwcv_beats = `DWCV_BEATS4;
        `DWCV_BL_OTF:    dwcv_beats = a12 ? `DWCV_BEATS8
                                          : `DWCV_BEATS4;
        default:         dwcv_beats = `DWCV_BEATS8;
      endcase
    end
  endfunction

  // software registers
  reg [31:0] mode_r;
  reg [31:0] timing_r;
  reg [31:0] lastwr_r;
  reg        viol_r;
  reg        space_err_r;
  reg        cwl_err_r;
  reg        recov_r;

  wire [1:0] bl_mode  = mode_r[`DWCV_MODE_BL_LSB+1:`DWCV_MODE_BL_LSB];
  wire       crc_en   = mode_r[`DWCV_MODE_CRC_BIT];
  wire       dm_en    = mode_r[`DWCV_MODE_DM_BIT];
  wire       pre2     = mode_r[`DWCV_MODE_PRE2_BIT];
  wire [7:0] cwl      = timing_r[`DWCV_TIM_CWL_LSB+7:`DWCV_TIM_CWL_LSB];
  wire [7:0] wr_nom   = timing_r[`DWCV_TIM_WR_LSB+7:`DWCV_TIM_WR_LSB];
  wire [7:0] wtr_nom  = timing_r[`DWCV_TIM_WTR_LSB+7:`DWCV_TIM_WTR_LSB];
  wire [7:0] crcdm_ad = timing_r[`DWCV_TIM_CRCDM_LSB+7:`DWCV_TIM_CRCDM_LSB];

  // write tracking state
  localparam ST_IDLE = 2'b00;
  localparam ST_LAT  = 2'b01;
  localparam ST_DATA = 2'b10;
  localparam ST_REC  = 2'b11;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg [7:0] gap_r;
  reg [3:0] beats_r;
  reg       chop_fixed_r;
  reg       bad_r;
  reg [7:0] rec_len_r;
  reg [7:0] wtr_len_r;

  // strobe tolerance: window is +/-six transitions, three ck cycles
  wire       tol_mode = ~crc_en & (bl_mode != `DWCV_BL_OTF);
  wire [7:0] win_ck   = {4'h0, `DWCV_DQS_WIN >> 1};
  wire       data_ck8 = (beats_r == `DWCV_BEATS8);
  wire [7:0] data_len = data_ck8 ? `DWCV_DATA_CK8 : `DWCV_DATA_CK4;
  wire       wr_go    = ck_rise & wr_s;
  // crc with mask lengthens both recovery and write-to-read
  wire [7:0] rec_len  = (crc_en & dm_en) ? wr_nom + crcdm_ad
                                         : wr_nom;
  wire [7:0] wtr_len  = (crc_en & dm_en) ? wtr_nom + crcdm_ad
                                         : wtr_nom;

  // one bit per ck rise for every write in flight, so that writes only
  // five clocks apart each report their own end of burst
  reg  [63:0] wr_line_r;
  reg  [63:0] len8_line_r;
  wire [7:0]  end8_ix = cwl + (`DWCV_DATA_CK8 - 8'h01);
  wire [7:0]  end4_ix = cwl + (`DWCV_DATA_CK4 - 8'h01);
  // limitation: a latency of 61 to 252 (63 to 254 for a four-beat chop) falls off the line and never ends
  wire        end8 = (end8_ix < 8'h40) & wr_line_r[end8_ix[5:0]] &
                     len8_line_r[end8_ix[5:0]];
  wire        end4 = (end4_ix < 8'h40) & wr_line_r[end4_ix[5:0]] &
                     ~len8_line_r[end4_ix[5:0]];

  // next state of the write tracker
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (ck_rise) begin
      case (state_r)
        ST_IDLE: begin
          if (wr_s) begin
            state_nxt = ST_LAT;
            cnt_nxt   = cwl;
          end
        end
        ST_LAT: begin
          // a seamless write retimes the window to the newest command
          if (wr_s) begin
            state_nxt = ST_LAT;
            cnt_nxt   = cwl;
          end else if (cnt_r <= 8'h01) begin
            state_nxt = ST_DATA;
            cnt_nxt   = data_len;
          end else begin
            cnt_nxt = cnt_r - 8'h01;
          end
        end
        ST_DATA: begin
          if (wr_s) begin
            // back-to-back write restarts latency; device never stalls
            state_nxt = ST_LAT;
            cnt_nxt   = cwl;
          end else if (cnt_r <= 8'h01) begin
            state_nxt = ST_REC;
            cnt_nxt   = rec_len;
          end else begin
            cnt_nxt = cnt_r - 8'h01;
          end
        end
        ST_REC: begin
          if (wr_s) begin
            state_nxt = ST_LAT;
            cnt_nxt   = cwl;
          end else if (cnt_r <= 8'h01) begin
            state_nxt = ST_IDLE;
            cnt_nxt   = 8'h00;
          end else begin
            cnt_nxt = cnt_r - 8'h01;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          cnt_nxt   = 8'h00;
        end
      endcase
    end
  end

  // tracker registers and burst capture
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r      <= ST_IDLE;
      cnt_r        <= 8'h00;
      gap_r        <= 8'hff;
      beats_r      <= `DWCV_BEATS8;
      chop_fixed_r <= 1'b0;
      bad_r        <= 1'b0;
      rec_len_r    <= 8'h00;
      wtr_len_r    <= 8'h00;
      wr_line_r    <= 64'h0000_0000_0000_0000;
      len8_line_r  <= 64'h0000_0000_0000_0000;
      burst_end_r  <= 1'b0;
      rd_grant_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      burst_end_r <= ck_rise & (end8 | end4);
      // shift every ck rise; bit 0 is the command just taken
      if (ck_rise) begin
        wr_line_r   <= {wr_line_r[62:0], wr_s};
        len8_line_r <= {len8_line_r[62:0],
                        dwcv_beats(bl_mode, a12_s) == `DWCV_BEATS8};
      end
      // reads are always served, even after an offending write
      rd_grant_r  <= ck_rise & rd_s;
      if (wr_go) begin
        beats_r      <= dwcv_beats(bl_mode, a12_s);
        chop_fixed_r <= (bl_mode == `DWCV_BL_FIXED4);
        // gap then equals the ck rises between two commands
        gap_r        <= 8'h01;
        rec_len_r    <= rec_len;
        wtr_len_r    <= wtr_len;
        bad_r        <= 1'b0;
      end else if (ck_rise && gap_r != 8'hff) begin
        gap_r <= gap_r + 8'h01;
      end
      // faults only mark the write in flight
      if (ck_rise && (state_r == ST_DATA || state_r == ST_LAT) &&
          (dqf_s || (dqsf_s && tol_mode && cnt_r <= win_ck)))
        bad_r <= 1'b1;
    end
  end

  // taint tracking: set wins over the idle clear
  wire dqs_major = ck_rise & dqsf_s & ~(tol_mode & (cnt_r <= win_ck)) &
                   (state_r == ST_LAT);
  wire taint_set = burst_end_r & bad_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      taint_r <= 1'b0;
      viol_r  <= 1'b0;
      recov_r <= 1'b0;
    end else begin
      if (taint_set)
        taint_r <= 1'b1;
      else if (ck_rise & pre_s & idle_s)
        taint_r <= 1'b0;
      // major violation is sticky until a full reset
      if (dqs_major)
        viol_r <= 1'b1;
      if (burst_end_r)
        recov_r <= chop_fixed_r;
    end
  end

  // controller-side spacing checks, reported only
  wire space_bad = wr_go & pre2 & crc_en &
                   (gap_r == `DWCV_CCD_FORBID);
  wire cwl_bad   = wr_go & pre2 & (cwl <= `DWCV_CWL_FORBID);

  // avalon-mm slave: one wait cycle on every access
  reg [1:0] wait_r;
  wire      acc = avs_read | avs_write;
  wire      ack = acc & (wait_r == `DWCV_BUS_WAIT);
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r          <= 2'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      mode_r          <= `DWCV_MODE_RST;
      timing_r        <= `DWCV_TIM_RST;
      lastwr_r        <= 32'h0000_0000;
      space_err_r     <= 1'b0;
      cwl_err_r       <= 1'b0;
    end else begin
      avs_waitrequest <= ~(acc & (wait_r == 2'h0));
      wait_r          <= (acc & ~ack) ? wait_r + 2'h1 : 2'h0;
      if (space_bad)
        space_err_r <= 1'b1;
      else if (ack & avs_write & (avs_address == `DWCV_REG_STATUS) &
               avs_writedata[`DWCV_ST_SPACE_ERR])
        space_err_r <= 1'b0;
      if (cwl_bad)
        cwl_err_r <= 1'b1;
      else if (ack & avs_write & (avs_address == `DWCV_REG_STATUS) &
               avs_writedata[`DWCV_ST_CWL_ERR])
        cwl_err_r <= 1'b0;
      if (burst_end_r)
        lastwr_r <= {8'h00, rec_len_r, wtr_len_r, 4'h0, beats_r};
      if (ack & avs_write) begin
        case (avs_address)
          `DWCV_REG_MODE:   mode_r   <= avs_writedata;
          `DWCV_REG_TIMING: timing_r <= avs_writedata;
          default: ;
        endcase
      end
      // loaded on the first request cycle so the word already stands
      // at the edge where waitrequest is sampled low
      if (avs_read & (wait_r == 2'h0)) begin
        case (avs_address)
          `DWCV_REG_MODE:   avs_readdata <= mode_r;
          `DWCV_REG_TIMING: avs_readdata <= timing_r;
          `DWCV_REG_STATUS: avs_readdata <= {26'h0, recov_r, cwl_err_r,
                                             space_err_r, taint_r,
                                             viol_r, (state_r != ST_IDLE)};
          `DWCV_REG_LASTWR: avs_readdata <= lastwr_r;
          default:          avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ---- src/dwcv_defs.vh ----
/*
 * constants for the write-path capture block: mode field codes, burst
 * lengths, column spacing, strobe window, register map and bus timing.
 * assumes plain Verilog-2005 and inclusion by bare name.
 */
`ifndef DWCV_DEFS_VH
`define DWCV_DEFS_VH

// burst length selection field codes
`define DWCV_BL_FIXED8      2'b00
`define DWCV_BL_OTF         2'b01
`define DWCV_BL_FIXED4      2'b10

// beats per burst
`define DWCV_BEATS8         4'h8
`define DWCV_BEATS4         4'h4

// ck cycles of data after write latency
`define DWCV_DATA_CK8       8'h04
`define DWCV_DATA_CK4       8'h02

// column spacing with crc and 1-clock preamble
`define DWCV_CCD_CRC        8'h05
// spacing forbidden in 2-clock preamble mode
`define DWCV_CCD_FORBID     8'h06
// cas write latency forbidden in 2-clock preamble mode
`define DWCV_CWL_FORBID     8'h09

// strobe tolerance window in transition edges
`define DWCV_DQS_WIN        4'h6

// register byte addresses
`define DWCV_REG_MODE       4'h0
`define DWCV_REG_TIMING     4'h4
`define DWCV_REG_STATUS     4'h8
`define DWCV_REG_LASTWR     4'hc

// mode register fields
`define DWCV_MODE_BL_LSB    0
`define DWCV_MODE_CRC_BIT   2
`define DWCV_MODE_DM_BIT    3
`define DWCV_MODE_PRE2_BIT  4

// timing register fields
`define DWCV_TIM_CWL_LSB    0
`define DWCV_TIM_WR_LSB     8
`define DWCV_TIM_WTR_LSB    16
`define DWCV_TIM_CRCDM_LSB  24

// reset values
`define DWCV_MODE_RST       32'h0000_0000
`define DWCV_TIM_RST        32'h0303_0c09

// status bits
`define DWCV_ST_BUSY        0
`define DWCV_ST_VIOL        1
`define DWCV_ST_TAINT       2
`define DWCV_ST_SPACE_ERR   3
`define DWCV_ST_CWL_ERR     4
`define DWCV_ST_RECOV       5

// wait cycles of the slave on every access, in core cycles
`define DWCV_BUS_WAIT       2'h1

`endif

// ---- src/dwcv_sync.v ----
/*
 * two-flop synchroniser for one level from another clock domain.
 * assumes the input is a plain level; no logic reads the first stage.
 */
`timescale 1ns/1ps
module dwcv_sync (
  input  wire core_clk,
  input  wire reset_n,
  input  wire async_in,
  output reg  sync_out
);

  reg meta_r;

  // second stage is the only reader of the first
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ---- src/dwcv_edge.v ----
/*
 * rising-edge finder on a synchronised link clock.
 * assumes lvl_in is already synchronised to core_clk.
 */
`timescale 1ns/1ps
module dwcv_edge (
  input  wire core_clk,
  input  wire reset_n,
  input  wire lvl_in,
  output wire rise
);

  reg last_r;

  // remembers the previous level to find the low-to-high step
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      last_r <= 1'b0;
    else
      last_r <= lvl_in;
  end

  assign rise = lvl_in & ~last_r;

endmodule

// ---- verification/dwcv_write_path_asserts.sv ----
/* port checker for the write-path tracker.
   assumes it is bound onto dwcv_write_path. */
`timescale 1ns/1ps
module dwcv_asserts (
  input wire        core_clk,
  input wire        reset_n,
  input wire        ck_pin,
  input wire        wr_cmd_pin,
  input wire        rd_cmd_pin,
  input wire        pre_cmd_pin,
  input wire        all_idle_pin,
  input wire        a12_pin,
  input wire        dqs_fault_pin,
  input wire        dq_fault_pin,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        burst_end_r,
  input wire        taint_r,
  input wire        rd_grant_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] pre_age_r;
  logic       wr_seen_r;
  // cycles since an idle precharge; slack covers the sync chain
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_age_r <= 4'hf;
      wr_seen_r <= 1'b0;
    end else begin
      pre_age_r <= (pre_cmd_pin && all_idle_pin) ? 4'h0 :
                   (&pre_age_r) ? pre_age_r : pre_age_r + 4'h1;
      wr_seen_r <= wr_seen_r | wr_cmd_pin;
    end
  end
  wait_answer_a: assert property ($rose(avs_read || avs_write) |->
    ##[1:2] !avs_waitrequest) else $error("bus answer late");
  wait_cause_a: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("answer without request");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer stood too long");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  burst_pulse_a: assert property (burst_end_r |=> !burst_end_r)
    else $error("burst end wider than a cycle");
  burst_cause_a: assert property (burst_end_r |-> wr_seen_r)
    else $error("burst end without write");
  grant_cause_a: assert property ($rose(rd_grant_r) |->
    $past(rd_cmd_pin, 3) || $past(rd_cmd_pin, 5))
    else $error("grant without read");
  taint_clear_a: assert property ($fell(taint_r) |-> pre_age_r < 4'h9)
    else $error("taint dropped without precharge");
  cover property (burst_end_r);
  cover property (rd_grant_r);
  cover property ($fell(taint_r));
endmodule

bind dwcv_write_path dwcv_asserts u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .ck_pin(ck_pin),
  .wr_cmd_pin(wr_cmd_pin), .rd_cmd_pin(rd_cmd_pin),
  .pre_cmd_pin(pre_cmd_pin), .all_idle_pin(all_idle_pin),
  .a12_pin(a12_pin), .dqs_fault_pin(dqs_fault_pin),
  .dq_fault_pin(dq_fault_pin), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .burst_end_r(burst_end_r),
  .taint_r(taint_r), .rd_grant_r(rd_grant_r));

// ---- verification/dwcv_ctrl_model.sv ----
/* controller model: free ck of 160 ns, one-ck commands, fault levels.
   assumes only the bench calls issue and nothing else drives the pins. */
`timescale 1ns/1ps
module dwcv_ctrl_model (
  output logic ck_pin,
  output logic wr_cmd_pin,
  output logic rd_cmd_pin,
  output logic pre_cmd_pin,
  output logic all_idle_pin,
  output logic a12_pin,
  output logic dqs_fault_pin,
  output logic dq_fault_pin
);
  // ck phase kept unrelated to the core clock
  initial begin
    {wr_cmd_pin, rd_cmd_pin, pre_cmd_pin, all_idle_pin} = 4'h0;
    {a12_pin, dqs_fault_pin, dq_fault_pin, ck_pin} = 4'h0;
    #7;
    forever #80 ck_pin = ~ck_pin;
  end
  // launched on a falling edge so it is steady at the taking rise;
  // gap is the ck count to the next command
  task automatic issue(input logic w, r, p, a, idle, dqs, dq,
                       input integer gap);
    @(negedge ck_pin);
    wr_cmd_pin <= w;
    rd_cmd_pin <= r;
    pre_cmd_pin <= p;
    a12_pin <= a;
    all_idle_pin <= idle;
    @(negedge ck_pin);
    wr_cmd_pin <= 1'b0;
    rd_cmd_pin <= 1'b0;
    pre_cmd_pin <= 1'b0;
    a12_pin <= ~a;
    // a fault shows only in the two clocks before data, inside the
    // strobe window at the default latency; gap is then not used
    if (dqs || dq) begin
      repeat (6) @(negedge ck_pin);
      dqs_fault_pin <= dqs;
      dq_fault_pin <= dq;
      repeat (2) @(negedge ck_pin);
      dqs_fault_pin <= 1'b0;
      dq_fault_pin <= 1'b0;
    end else repeat (gap - 2) @(negedge ck_pin);
  endtask
endmodule

// ---- verification/dram_write_crc_and_violation_rules_tb.sv ----
/* bench for the write-path tracker: registers, burst length, spacing
   flags and fault confinement. assumes the controller model. */
`timescale 1ns/1ps
`include "dwcv_defs.vh"
module dram_write_crc_and_violation_rules_tb;
  localparam logic [31:0] zero = 32'h0000_0000;
  logic        core_clk, reset_n, avs_read, avs_write, a, cd;
  logic [3:0]  avs_address;
  logic [1:0]  bl;
  logic [31:0] avs_writedata, q, ck_cnt, ck_tot, lat, end_a, end_b;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, burst_end_r, taint_r, rd_grant_r;
  wire         ck_pin, wr_cmd_pin, rd_cmd_pin, pre_cmd_pin;
  wire         all_idle_pin, a12_pin, dqs_fault_pin, dq_fault_pin;
  integer      seed, n_errors, check_count, cyc, n_end, n_grant, i;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  dwcv_ctrl_model m (.ck_pin(ck_pin), .wr_cmd_pin(wr_cmd_pin),
    .rd_cmd_pin(rd_cmd_pin), .pre_cmd_pin(pre_cmd_pin),
    .all_idle_pin(all_idle_pin), .a12_pin(a12_pin),
    .dqs_fault_pin(dqs_fault_pin), .dq_fault_pin(dq_fault_pin));
  dwcv_write_path DUT (.core_clk(core_clk), .reset_n(reset_n),
    .ck_pin(ck_pin), .wr_cmd_pin(wr_cmd_pin), .rd_cmd_pin(rd_cmd_pin),
    .pre_cmd_pin(pre_cmd_pin), .all_idle_pin(all_idle_pin),
    .a12_pin(a12_pin), .dqs_fault_pin(dqs_fault_pin),
    .dq_fault_pin(dq_fault_pin), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .burst_end_r(burst_end_r),
    .taint_r(taint_r), .rd_grant_r(rd_grant_r));

  // ck rises since the last write and in total
  always @(posedge ck_pin) begin
    ck_tot <= ck_tot + 1;
    ck_cnt <= wr_cmd_pin ? zero : ck_cnt + 1;
  end
  // burst ends, grants and the hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (burst_end_r === 1'b1) begin
      n_end <= n_end + 1;
      lat <= ck_cnt;
      end_a <= end_b;
      end_b <= ck_tot;
    end
    if (rd_grant_r === 1'b1) n_grant <= n_grant + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] ad,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_end(input integer k);
    while (n_end < k) @(posedge core_clk);
    @(posedge core_clk);
  endtask
  function automatic logic [31:0] beats(input logic [1:0] b, input logic x);
    beats = (b == `DWCV_BL_FIXED4 || (b == `DWCV_BL_OTF && !x)) ?
            32'h0000_0004 : 32'h0000_0008;
  endfunction
  task automatic wr_test(input logic [1:0] b, input logic x, c);
    integer k;
    k = n_end + 1;
    bus(1'b1, `DWCV_REG_MODE, {28'h000_0000, c, c, b});
    m.issue(1, 0, 0, x, 0, 0, 0, 2);
    wait_end(k);
    chk("latency", 32'h0000_0009 + beats(b, x) / 2, lat);
    bus(1'b0, `DWCV_REG_LASTWR, zero);
    chk("beats", beats(b, x), q & 32'h0000_000f);
    chk("recovery", {c ? 8'h0f : 8'h0c, c ? 8'h06 : 8'h03}, q[23:8]);
  endtask

  initial begin
    {seed, n_errors, check_count, cyc, n_end, n_grant} = {33, 0, 0, 0, 0, 0};
    {ck_cnt, ck_tot, avs_writedata} = {zero, zero, zero};
    {reset_n, avs_read, avs_write, avs_address} = 7'h00;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(1'b0, `DWCV_REG_MODE, zero);
    chk("mode", `DWCV_MODE_RST, q);
    bus(1'b0, `DWCV_REG_TIMING, zero);
    chk("timing", `DWCV_TIM_RST, q);
    bus(1'b1, 4'h6, 32'hffff_ffff);
    bus(1'b0, 4'h6, zero);
    chk("unmapped", zero, q);
    // all burst modes with both a12 levels, then random ones
    for (i = 0; i < 12; i++) begin
      bl = (i < 6) ? 2'(i % 3) : 2'($unsigned($random(seed)) % 3);
      a = (i < 6) ? (i > 2) : $random(seed);
      cd = (i < 6) ? i[0] : $random(seed);
      wr_test(bl, a, cd);
    end
    // crc writes five clocks apart stay seamless
    bus(1'b1, `DWCV_REG_MODE, 32'h0000_0004);
    i = n_end + 2;
    m.issue(1, 0, 0, 1, 0, 0, 0, 5);
    m.issue(1, 0, 0, 1, 0, 0, 0, 2);
    wait_end(i);
    chk("crc gap", 32'h0000_0005, end_b - end_a);
    bus(1'b0, `DWCV_REG_STATUS, zero);
    chk("gap flag", zero, q & 32'h0000_0008);
    // two-clock preamble: cwl 9 flagged, six-clock spacing flagged
    bus(1'b1, `DWCV_REG_MODE, 32'h0000_0014);
    m.issue(1, 0, 0, 1, 0, 0, 0, 2);
    wait_end(n_end + 1);
    bus(1'b0, `DWCV_REG_STATUS, zero);
    chk("cwl flag", 32'h0000_0010, q & 32'h0000_0010);
    bus(1'b1, `DWCV_REG_TIMING, 32'h0303_0c0a);
    bus(1'b1, `DWCV_REG_STATUS, 32'h0000_0018);
    bus(1'b0, `DWCV_REG_STATUS, zero);
    chk("flags cleared", zero, q & 32'h0000_0018);
    i = n_end + 2;
    m.issue(1, 0, 0, 1, 0, 0, 0, 6);
    m.issue(1, 0, 0, 1, 0, 0, 0, 2);
    wait_end(i);
    bus(1'b0, `DWCV_REG_STATUS, zero);
    chk("six gap flag", 32'h0000_0008, q & 32'h0000_0008);
    bus(1'b1, `DWCV_REG_TIMING, `DWCV_TIM_RST);
    bus(1'b1, `DWCV_REG_MODE, zero);
    // faults taint only their write; reads and writes still served
    m.issue(1, 0, 0, 1, 0, 0, 1, 2);
    wait_end(n_end + 1);
    chk("taint", 32'h0000_0001, {31'h0000_0000, taint_r});
    i = n_grant + 1;
    m.issue(0, 1, 0, 0, 0, 0, 0, 2);
    m.issue(1, 0, 0, 0, 0, 1, 0, 2);
    wait_end(n_end + 1);
    chk("grant", i, n_grant);
    bus(1'b0, `DWCV_REG_STATUS, zero);
    chk("minor only", 32'h0000_0004, q & 32'h0000_0006);
    m.issue(0, 0, 1, 0, 1, 0, 0, 2);
    m.issue(1, 0, 0, 1, 1, 0, 0, 2);
    wait_end(n_end + 1);
    chk("taint gone", zero, {31'h0000_0000, taint_r});
    // crc on: a strobe fault is out of tolerance and sticks until reset
    bus(1'b1, `DWCV_REG_MODE, 32'h0000_0004);
    m.issue(1, 0, 0, 1, 0, 1, 0, 2);
    wait_end(n_end + 1);
    bus(1'b0, `DWCV_REG_STATUS, zero);
    chk("major viol", 32'h0000_0002, q & 32'h0000_0002);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(1'b0, `DWCV_REG_STATUS, zero);
    chk("viol reset", zero, q & 32'h0000_0006);
    complete_run;
  end
endmodule
